// [hw/gpsg_port.sv]
// Purpose: one 8-pin general-purpose port with pull-ups, bit access and sleep gating
// Assumes: 10 MHz i_clk, synchronous active-low i_rstn, pins resolved outside
// Notes:   register reads answer one cycle after the address is presented
//
// Contract
// - single-bit set or clear changes only the addressed bit of that register.
// - each pin has its own pull-up enable, independent of all others.
// - port occupies three io addresses: output data, direction, input value.
// - input value location is read-only; output data and direction are read/write.
// - global pull-up disable turns off every pull-up regardless of pin settings.
// - deep sleep, with io and converter clocks stopped, disables input buffers.
// - pins needed for wake-up keep their input path during deep sleep.
// - alternate function on some pins leaves the other pins' io behaviour alone.
// - direction bit one makes the pin an output, zero an input.
// - input with data bit one gets pull-up; output drives the data bit.
// - all pins float high-impedance while reset is held, clock or not.
// - pin reads pass a two-stage synchroniser before the input value register.

`timescale 1ns/1ps

// ------------------------------------------------------------------
// shared constants
// ------------------------------------------------------------------
// kept ahead of every module that imports it, as long as this file is compiled first
package gpsg_pkg;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned ADDR_W    = 2;
  // three io locations per port
  localparam logic [1:0]  ADDR_IN   = 2'h0;
  localparam logic [1:0]  ADDR_DIR  = 2'h1;
  localparam logic [1:0]  ADDR_OUT  = 2'h2;
  // reset values: every pin an input, pull-up off
  localparam logic [7:0]  RST_OUT   = 8'h00;
  localparam logic [7:0]  RST_DIR   = 8'h00;
  localparam logic [7:0]  RST_RDATA = 8'h00;
  localparam logic [7:0]  ALL_ONES  = 8'hff;
  localparam logic [7:0]  ALL_ZERO  = 8'h00;
  localparam logic [7:0]  ONE_HOT0  = 8'h01;
endpackage : gpsg_pkg

// ------------------------------------------------------------------
// port
// ------------------------------------------------------------------
module gpsg_port
  import gpsg_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // byte access
  input  wire logic [ADDR_W-1:0] i_io_addr,
  input  wire logic              i_io_wr,
  input  wire logic [PORT_W-1:0] i_io_wdata,
  output logic      [PORT_W-1:0] o_io_rdata,
  // single-bit set and clear
  input  wire logic              i_set_io_bit_instr,
  input  wire logic              i_clear_io_bit_instr,
  input  wire logic [ADDR_W-1:0] i_bit_addr,
  input  wire logic [IDX_W-1:0]  i_bit_idx,
  // loose control bits
  input  wire logic              i_global_pullup_disable,
  input  wire logic              i_deep_sleep,
  input  wire logic [PORT_W-1:0] i_wake_pin_mask,
  // alternate function overrides
  input  wire logic [PORT_W-1:0] i_alt_en,
  input  wire logic [PORT_W-1:0] i_alt_oe,
  input  wire logic [PORT_W-1:0] i_alt_out,
  // pins
  input  wire logic [PORT_W-1:0] i_pin,
  output logic      [PORT_W-1:0] o_pin,
  output logic      [PORT_W-1:0] o_pin_oe,
  output logic      [PORT_W-1:0] o_pullup_en,
  output logic      [PORT_W-1:0] o_input_en,
  output logic      [PORT_W-1:0] o_port_input_value_reg,
  output logic      [PORT_W-1:0] o_port_output_data_reg,
  output logic      [PORT_W-1:0] o_port_direction_reg
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot mask of a pin index, shared by update and checks
  function automatic logic [PORT_W-1:0] gpsg_bit_mask(input logic [IDX_W-1:0] idx);
    gpsg_bit_mask = ONE_HOT0 << idx;
  endfunction : gpsg_bit_mask

  typedef struct packed {
    logic [PORT_W-1:0] out_data;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] rdata;
  } gpsg_state_t;

  gpsg_state_t       st;
  gpsg_state_t       next_st;
  logic [PORT_W-1:0] bit_mask;
  logic [PORT_W-1:0] pin_gated;
  logic [PORT_W-1:0] pin_value;

  assign bit_mask = gpsg_bit_mask(i_bit_idx);

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // clamp to ground when the buffer is off so a floating pin reads low
  assign pin_gated = i_pin & o_input_en;

  gpsg_sync #(
    .SYNC_W  (PORT_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (pin_gated),
    .o_sync  (pin_value)
  );

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  // byte write first, bit op on top, so a bit op never loses to a stale byte
  always_comb begin
    next_st = st;
    if (i_io_wr && (i_io_addr == ADDR_OUT)) begin
      next_st.out_data = i_io_wdata;
    end
    if (i_io_wr && (i_io_addr == ADDR_DIR)) begin
      next_st.dir = i_io_wdata;
    end
    // input location takes no write at all
    if (i_set_io_bit_instr && (i_bit_addr == ADDR_OUT)) begin
      next_st.out_data = next_st.out_data | bit_mask;
    end
    if (i_clear_io_bit_instr && (i_bit_addr == ADDR_OUT)) begin
      next_st.out_data = next_st.out_data & ~bit_mask;
    end
    if (i_set_io_bit_instr && (i_bit_addr == ADDR_DIR)) begin
      next_st.dir = next_st.dir | bit_mask;
    end
    if (i_clear_io_bit_instr && (i_bit_addr == ADDR_DIR)) begin
      next_st.dir = next_st.dir & ~bit_mask;
    end
    // read data registered, one cycle latency
    unique case (i_io_addr)
      ADDR_IN:  next_st.rdata = pin_value;
      ADDR_DIR: next_st.rdata = st.dir;
      ADDR_OUT: next_st.rdata = st.out_data;
      default:  next_st.rdata = ALL_ZERO;
    endcase
    if (!i_rstn) begin
      next_st.out_data = RST_OUT;
      next_st.dir      = RST_DIR;
      next_st.rdata    = RST_RDATA;
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // per-pin drive, pull-up and input enable
  // ----------------------------------------------------------------
  // reset gating is combinational so pins float even with the clock stopped
  for (genvar n = 0; n < PORT_W; n++) begin : g_pin
    always_comb begin
      if (i_alt_en[n]) begin
        o_pin_oe[n] = i_alt_oe[n] & i_rstn;
        o_pin[n]    = i_alt_out[n];
        o_pullup_en[n] = 1'b0;
      end else begin
        o_pin_oe[n] = st.dir[n] & i_rstn;
        o_pin[n]    = st.out_data[n];
        o_pullup_en[n] = ~st.dir[n] & st.out_data[n]
                       & ~i_global_pullup_disable & i_rstn;
      end
      // wake pins stay live in deep sleep
      o_input_en[n] = ~i_deep_sleep | i_wake_pin_mask[n];
    end
  end

  assign o_io_rdata             = st.rdata;
  assign o_port_input_value_reg = pin_value;
  assign o_port_output_data_reg = st.out_data;
  assign o_port_direction_reg   = st.dir;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking

  a_bit_set_isolated: assert property (disable iff (!i_rstn)
    (i_set_io_bit_instr && !i_clear_io_bit_instr && !i_io_wr && i_bit_addr == ADDR_OUT)
    |=> (st.out_data == ($past(st.out_data) | gpsg_bit_mask($past(i_bit_idx)))))
    else $error("bit set disturbed other output bits");

  a_bit_clr_isolated: assert property (disable iff (!i_rstn)
    (i_clear_io_bit_instr && !i_set_io_bit_instr && !i_io_wr && i_bit_addr == ADDR_DIR)
    |=> (st.dir == ($past(st.dir) & ~gpsg_bit_mask($past(i_bit_idx)))))
    else $error("bit clear disturbed other direction bits");

  a_input_read_only: assert property (disable iff (!i_rstn)
    (i_io_wr && i_io_addr == ADDR_IN && !i_set_io_bit_instr && !i_clear_io_bit_instr)
    |=> $stable(st.out_data) && $stable(st.dir))
    else $error("write to input location changed a register");

  a_pullup_global_off: assert property (
    i_global_pullup_disable |-> (o_pullup_en == ALL_ZERO))
    else $error("pull-up active under global disable");

  a_reset_hiz: assert property (
    !i_rstn |-> (o_pin_oe == ALL_ZERO) && (o_pullup_en == ALL_ZERO))
    else $error("pin driven or pulled during reset");

  a_reset_regs_zero: assert property (
    !i_rstn |=> (st.out_data == RST_OUT) && (st.dir == RST_DIR))
    else $error("registers not cleared by reset");

  a_sleep_gate: assert property (
    i_deep_sleep |-> ((o_input_en & ~i_wake_pin_mask) == ALL_ZERO)
                     && ((o_input_en & i_wake_pin_mask) == i_wake_pin_mask))
    else $error("input buffer gating wrong in deep sleep");

  a_sync_two_stage: assert property (disable iff (!i_rstn)
    $past(i_rstn) && $past(i_rstn, 2)
    |-> (o_port_input_value_reg == $past(pin_gated, 2)))
    else $error("pin value not delayed by two stages");

  a_gpio_drive: assert property (disable iff (!i_rstn)
    ((o_pin_oe & ~i_alt_en) == (st.dir & ~i_alt_en))
    && (((o_pin ^ st.out_data) & ~i_alt_en) == ALL_ZERO))
    else $error("general pin drive wrong beside alternate pins");

  c_pullup_input: cover property (disable iff (!i_rstn)
    (o_pullup_en != ALL_ZERO) ##1 i_global_pullup_disable);
  c_sleep_wake: cover property (disable iff (!i_rstn)
    i_deep_sleep && (i_wake_pin_mask != ALL_ZERO));
  c_bit_then_read: cover property (disable iff (!i_rstn)
    i_set_io_bit_instr ##1 (!i_io_wr && i_io_addr == ADDR_OUT) ##1 (o_io_rdata != ALL_ZERO));

endmodule : gpsg_port

// [hw/gpsg_sync.sv]
// Purpose: two-stage pin input synchroniser for the port
// Assumes: one clock domain, synchronous active-low reset
// Notes:   the first stage stands in for the transparent-high latch of the pin path;
//          width comes in as a parameter so this file needs no package before it

`timescale 1ns/1ps

// ------------------------------------------------------------------
// two-flop synchroniser, whole state in one struct
// ------------------------------------------------------------------
module gpsg_sync #(
  parameter int unsigned SYNC_W = 8                // the port passes its own width
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic [SYNC_W-1:0] i_async,
  output logic      [SYNC_W-1:0] o_sync
);
  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } gpsg_sync_t;

  gpsg_sync_t st;
  gpsg_sync_t next_st;

  // stage1 feeds only stage2, nothing else looks at it
  always_comb begin
    next_st        = st;
    next_st.stage1 = i_async;
    next_st.stage2 = st.stage1;
    if (!i_rstn) begin
      next_st = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_sync = st.stage2;
endmodule : gpsg_sync

// [verif/gpsg_board.sv]
// Purpose: board-side model of the port pins, resolving each pin level
// Assumes: design drive wins over the board driver when both are on
// Notes:   floating pins toggle every cycle so a missing drive never reads clean

`timescale 1ns/1ps

module gpsg_board (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_drive,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_ext_val,
  output logic      [7:0] o_level
);
  logic [7:0] float_q = 8'h55;

  // -------------------------------------------------
  // pin resolution
  // -------------------------------------------------
  // nba so the toggle lands after the design has sampled the pins
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  // design drive, then board drive, then pull-up, else a wandering level
  always_comb begin
    o_level = (i_oe & i_drive) | (~i_oe & i_ext_en & i_ext_val)
            | (~i_oe & ~i_ext_en & (i_pullup | (~i_pullup & float_q)));
  end
endmodule : gpsg_board

// [verif/testbench.sv]
// Purpose: random self-checking bench for the port, against an integer model
// Assumes: inputs change on the falling edge; checks run before each change
// Notes:   read data is checked every cycle; a same-edge write shows only a cycle later

`timescale 1ns/1ps

module testbench;
  import gpsg_pkg::*;
  logic       clk, rstn, wr, setb, clrb, global_pullup_disable, slp;
  logic [1:0] addr, baddr;
  logic [2:0] idx;
  logic [7:0] wd, wake, aen, aoe, aout, xen, xval, lvl, rd;
  logic [7:0] pdrv, poe, pu, ie, piv, pout, pdir;
  int         n_fail, check_count, m_out, m_dir, s1, s2, m_rd, mode;

  gpsg_port uut (.i_clk(clk), .i_rstn(rstn), .i_io_addr(addr), .i_io_wr(wr),
    .i_io_wdata(wd), .o_io_rdata(rd), .i_set_io_bit_instr(setb),
    .i_clear_io_bit_instr(clrb), .i_bit_addr(baddr), .i_bit_idx(idx),
    .i_global_pullup_disable(global_pullup_disable), .i_deep_sleep(slp), .i_wake_pin_mask(wake),
    .i_alt_en(aen), .i_alt_oe(aoe), .i_alt_out(aout), .i_pin(lvl), .o_pin(pdrv),
    .o_pin_oe(poe), .o_pullup_en(pu), .o_input_en(ie), .o_port_input_value_reg(piv),
    .o_port_output_data_reg(pout), .o_port_direction_reg(pdir));
  gpsg_board board (.i_clk(clk), .i_drive(pdrv), .i_oe(poe), .i_pullup(pu),
    .i_ext_en(xen), .i_ext_val(xval), .o_level(lvl));

  // -------------------------------------------------
  // reference model, updated at the same edge as the design
  // -------------------------------------------------
  always @(posedge clk) begin
    m_rd = (addr == 2'h1) ? m_dir : (addr == 2'h2) ? m_out : (addr == 2'h0) ? s2 : 0;
    if (wr && addr == 2'h1) m_dir = wd;
    if (wr && addr == 2'h2) m_out = wd;
    if (setb && baddr == 2'h1) m_dir = m_dir | (1 << idx);
    if (setb && baddr == 2'h2) m_out = m_out | (1 << idx);
    if (clrb && baddr == 2'h1) m_dir = m_dir & ~(1 << idx);
    if (clrb && baddr == 2'h2) m_out = m_out & ~(1 << idx);
    s2 = s1;
    s1 = lvl & (slp ? wake : 8'hff);
    if (!rstn) begin
      {m_out, m_dir, s1, s2, m_rd} = '0;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // compare every observable against the model
  task automatic compare();
    logic [7:0] eoe, epu, edrv;
    eoe  = rstn ? ((aen & aoe) | (~aen & m_dir[7:0])) : 8'h00;
    epu  = (rstn && !global_pullup_disable) ? (~m_dir[7:0] & m_out[7:0] & ~aen) : 8'h00;
    edrv = ((aen & aout) | (~aen & m_out[7:0])) & eoe;
    chk("dir", m_dir[7:0], pdir);
    chk("out", m_out[7:0], pout);
    chk("oe", eoe, poe);
    chk("drive", edrv, pdrv & eoe);
    chk("pullup", epu, pu);
    chk("input_en", slp ? wake : 8'hff, ie);
    chk("sync", s2[7:0], piv);
    chk("rdata", m_rd[7:0], rd);
  endtask : compare

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // -------------------------------------------------
  // stimulus: plain, then deep sleep, then alternate overrides
  // -------------------------------------------------
  initial begin
    {rstn, wr, setb, clrb, global_pullup_disable, slp, addr, baddr, idx} = '0;
    {wd, wake, aen, aoe, aout, xen, xval} = '0;
    {n_fail, check_count, m_out, m_dir, s1, s2, m_rd} = '0;
    void'($urandom(52422));
    repeat (20) @(negedge clk);
    for (int i = 0; i < 3000; i++) begin
      mode = i / 1000;
      rstn = (i == 0) || ($urandom % 97 != 0); // rare mid-run reset
      wr   = 1'($urandom);
      addr = 2'($urandom);
      wd   = 8'($urandom);
      setb = ($urandom % 3 == 0);
      clrb = ($urandom % 3 == 0); // overlap with set tests clear priority
      baddr = 2'($urandom);
      idx  = 3'($urandom);
      global_pullup_disable  = ($urandom % 4 == 0);
      slp  = (mode == 1) && 1'($urandom);
      wake = 8'($urandom);
      aen  = (mode == 2) ? 8'($urandom) : 8'h00;
      aoe  = 8'($urandom);
      aout = 8'($urandom);
      xen  = 8'($urandom);
      xval = 8'($urandom);
      @(negedge clk);
      compare();
    end
    end_sim();
  end
endmodule : testbench
